// ===== verilog/lbc_local_bus_ctl.sv
// Notes on behaviour
// - data strobe low through every data state
// - own line drivers off all_outputs_float_test_mode read strobe asserts
// - strobe release means read data captured
// - strobe and direction high during reset
// - direction low for read/ack, high write
// - direction never changes while strobe asserted
// - no ready in data state adds wait
// - read-modify-write waits while others hold lock
// - lock on at read address, off at write
// - lock held through interrupt acknowledge
// - lock low at reset end floats everything
// - two active-low byte-lane selects per data cycle
// - final beat low in last data state
// - failure shown as final beat, selects off
// - failure held during self-test, cleared on pass
// - sixteen-word zero checksum (two eight-word bursts), failure sticks on mismatch
// - on hold request float, then acknowledge, hold
// - request withdrawn drops acknowledge, back to idle
// - grant acknowledge driven except in float mode, low in reset
// - word address advances each burst beat
// - processor tick is input clock divided two
// - write/read latched at address, stable after
`default_nettype none
module lbc_local_bus_ctl #(
  parameter int unsigned SELFTEST_CYCLES = lbc_pkg::SELFTEST_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request side
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic req_rmw_i,
  input wire logic req_inta_i,
  input wire logic [2:0] req_last_beat_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic [1:0] req_be_n_i,
  input wire logic selftest_ok_i,
  // read data side
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [15:0] rd_data_o,
  // bus pins
  input wire logic [15:0] ad_i,
  output logic [15:0] ad_o,
  output logic ad_oe_o,
  output logic data_strobe_n_o,
  output logic transfer_direction_o,
  output logic strobe_dir_oe_o,
  output logic write_read_o,
  output logic [2:0] word_address_outputs_o,
  output logic [1:0] byte_lane_selects_o,
  output logic final_beat_n_o,
  output logic bus_oe_o,
  input wire logic ready_n_i,
  input wire logic lock_n_i,
  output logic lock_n_o,
  output logic lock_oe_o,
  input wire logic hold_i,
  output logic bus_grant_ack_o,
  output logic grant_oe_o,
  output logic all_outputs_float_test_mode_o,
  output logic proc_clk_o
);
  localparam int unsigned ST_W = $clog2(SELFTEST_CYCLES + 1);
  localparam logic [ST_W-1:0] ST_LAST = ST_W'(SELFTEST_CYCLES - 1);

  if (SELFTEST_CYCLES < 1)
  begin : g_bad_selftest
    $error("self-test length must be at least one tick");
  end

  typedef struct packed {
    logic phase;
    logic first;
    logic float_all;
    lbc_pkg::lbc_init_type mode;
    logic [ST_W-1:0] st_cnt;
    lbc_pkg::lbc_bus_type state;
    logic pend;
    logic wr;
    logic read_modify_write_sequence;
    logic inta;
    logic intern;
    logic [2:0] beats;
    logic [2:0] wa;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0] be_n;
    logic lock_on;
    logic [1:0] chk_idx;
    logic [31:0] sum;
    logic [15:0] b0;
    logic [15:0] b1;
    logic [1:0] cnt;
    logic strobe_n;
    logic dir;
    logic [15:0] ad;
    logic ad_oe;
    logic [1:0] be_out;
    logic final_n;
    logic bus_oe;
    logic sd_oe;
    logic grant;
    logic goe;
    logic rv;
    logic req_rdy;
  } lbc_state_type;

  lbc_state_type s_ff;
  lbc_state_type nxt_s;

  // ==========================================================
  // pin synchronisers
  // no reset here: the lock level must be seen at the first edge after release
  logic lk_s1_ff, lk_s2_ff, hold_s1_ff, hold_s2_ff, rdy_s1_ff, rdy_s2_ff;
  logic [15:0] ad_s1_ff, ad_s2_ff;

  always_ff @(posedge clk_i)
  begin
    lk_s1_ff <= lock_n_i;
    lk_s2_ff <= lk_s1_ff;
    hold_s1_ff <= hold_i;
    hold_s2_ff <= hold_s1_ff;
    rdy_s1_ff <= ready_n_i;
    rdy_s2_ff <= rdy_s1_ff;
    ad_s1_ff <= ad_i;
    ad_s2_ff <= ad_s1_ff;
  end

  // ==========================================================
  // sequencer
  logic foreign_lock, beat_ok, push, pop, fail;

  always_comb
  begin
    nxt_s = s_ff;
    push = 1'b0;
    nxt_s.phase = ~s_ff.phase;
    nxt_s.first = 1'b1;
    if (!s_ff.first)
      nxt_s.float_all = ~lk_s2_ff;
    foreign_lock = ~lk_s2_ff & ~s_ff.lock_on;
    pop = (s_ff.cnt != 2'h0) & rd_ready_i;
    beat_ok = ~rdy_s2_ff & (s_ff.wr | s_ff.intern | (s_ff.cnt != lbc_pkg::BUF_DEPTH));
    if (s_ff.phase && s_ff.first && !s_ff.float_all)
    begin
      if (s_ff.mode == lbc_pkg::INI_TEST)
      begin
        nxt_s.st_cnt = s_ff.st_cnt + 1'b1;
        if (s_ff.st_cnt == ST_LAST)
          nxt_s.mode = selftest_ok_i ? lbc_pkg::INI_SUM : lbc_pkg::INI_FAIL;
      end
      unique case (s_ff.state)
        lbc_pkg::BUS_IDLE:
        begin
          if (req_valid_i && s_ff.req_rdy)
          begin
            nxt_s.pend = 1'b1;
            nxt_s.wr = req_write_i & ~req_rmw_i & ~req_inta_i;
            nxt_s.read_modify_write_sequence = req_rmw_i;
            nxt_s.inta = req_inta_i & ~req_rmw_i;
            nxt_s.intern = 1'b0;
            nxt_s.beats = (req_rmw_i | req_inta_i | req_write_i) ? 3'h0 : req_last_beat_i;
            nxt_s.wa = req_addr_i[3:1];
            nxt_s.addr = req_addr_i;
            nxt_s.wdata = req_wdata_i;
            nxt_s.be_n = req_be_n_i;
          end
          else if (s_ff.pend)
          begin
            if (!(s_ff.read_modify_write_sequence && foreign_lock))
            begin
              nxt_s.pend = 1'b0;
              nxt_s.state = lbc_pkg::BUS_ADDR;
              nxt_s.lock_on = s_ff.read_modify_write_sequence | s_ff.inta;
            end
          end
          else if (hold_s2_ff)
            nxt_s.state = lbc_pkg::BUS_REL;
          else if (s_ff.mode == lbc_pkg::INI_SUM)
          begin
            if (s_ff.chk_idx == lbc_pkg::CHK_BURSTS)
              nxt_s.mode = (s_ff.sum == lbc_pkg::CHK_EXPECT) ? lbc_pkg::INI_RUN : lbc_pkg::INI_FAIL;
            else
            begin
              nxt_s.state = lbc_pkg::BUS_ADDR;
              nxt_s.wr = 1'b0;
              nxt_s.read_modify_write_sequence = 1'b0;
              nxt_s.inta = 1'b0;
              nxt_s.intern = 1'b1;
              nxt_s.beats = lbc_pkg::CHK_LAST_BEAT;
              nxt_s.wa = 3'h0;
              nxt_s.addr = 16'(s_ff.chk_idx * lbc_pkg::CHK_STEP);
              nxt_s.be_n = 2'h0;
              nxt_s.chk_idx = s_ff.chk_idx + 2'h1;
            end
          end
        end
        lbc_pkg::BUS_ADDR:
          nxt_s.state = lbc_pkg::BUS_DATA;
        lbc_pkg::BUS_DATA:
        begin
          if (beat_ok)
          begin
            if (s_ff.intern)
              nxt_s.sum = s_ff.sum + (s_ff.wa[0] ? {ad_s2_ff, 16'h0000} : {16'h0000, ad_s2_ff});
            else if (!s_ff.wr)
              push = 1'b1;
            if (s_ff.beats != 3'h0)
            begin
              nxt_s.beats = s_ff.beats - 3'h1;
              nxt_s.wa = s_ff.wa + 3'h1;
            end
            else if (s_ff.read_modify_write_sequence && !s_ff.wr)
            begin
              nxt_s.state = lbc_pkg::BUS_ADDR;
              nxt_s.wr = 1'b1;
              nxt_s.lock_on = 1'b0;
            end
            else
            begin
              nxt_s.state = lbc_pkg::BUS_IDLE;
              nxt_s.lock_on = 1'b0;
            end
          end
        end
        lbc_pkg::BUS_REL:
          nxt_s.state = lbc_pkg::BUS_HOLD;
        lbc_pkg::BUS_HOLD:
          if (!hold_s2_ff)
            nxt_s.state = lbc_pkg::BUS_IDLE;
        default:
          nxt_s.state = lbc_pkg::BUS_IDLE;
      endcase
    end
    // two-entry read buffer; a full buffer stretches the data state
    if (pop)
    begin
      nxt_s.b0 = s_ff.b1;
      nxt_s.cnt = s_ff.cnt - 2'h1;
    end
    if (push)
    begin
      if (nxt_s.cnt == 2'h0)
        nxt_s.b0 = ad_s2_ff;
      else
        nxt_s.b1 = ad_s2_ff;
      nxt_s.cnt = nxt_s.cnt + 2'h1;
    end
    // registered pin values
    fail = (nxt_s.mode == lbc_pkg::INI_TEST) | (nxt_s.mode == lbc_pkg::INI_FAIL);
    nxt_s.strobe_n = nxt_s.state != lbc_pkg::BUS_DATA;
    if (nxt_s.state == lbc_pkg::BUS_ADDR)
      nxt_s.dir = nxt_s.wr;
    nxt_s.ad = (nxt_s.state == lbc_pkg::BUS_ADDR) ? nxt_s.addr : nxt_s.wdata;
    nxt_s.ad_oe = ~nxt_s.float_all & ((nxt_s.state == lbc_pkg::BUS_ADDR)
                  | ((nxt_s.state == lbc_pkg::BUS_DATA) & nxt_s.wr));
    nxt_s.be_out = (nxt_s.state == lbc_pkg::BUS_DATA) ? nxt_s.be_n : lbc_pkg::BE_OFF_N;
    nxt_s.final_n = ~(fail | ((nxt_s.state == lbc_pkg::BUS_DATA) & (nxt_s.beats == 3'h0)));
    nxt_s.sd_oe = ~nxt_s.float_all & (nxt_s.state != lbc_pkg::BUS_REL) & (nxt_s.state != lbc_pkg::BUS_HOLD);
    nxt_s.bus_oe = nxt_s.sd_oe;
    nxt_s.grant = nxt_s.state == lbc_pkg::BUS_HOLD;
    nxt_s.goe = ~nxt_s.float_all;
    nxt_s.rv = nxt_s.cnt != 2'h0;
    nxt_s.req_rdy = nxt_s.phase & (nxt_s.state == lbc_pkg::BUS_IDLE) & ~nxt_s.pend
                    & (nxt_s.mode == lbc_pkg::INI_RUN) & ~nxt_s.float_all;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_ff <= '0;
      s_ff.strobe_n <= lbc_pkg::STROBE_RST;
      s_ff.dir <= lbc_pkg::DIR_RST;
      s_ff.sd_oe <= 1'b1;
      s_ff.final_n <= 1'b1;
      s_ff.be_out <= lbc_pkg::BE_OFF_N;
      s_ff.grant <= lbc_pkg::GRANT_RST;
      s_ff.goe <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  // ==========================================================
  // outputs
  assign req_ready_o = s_ff.req_rdy;
  assign rd_valid_o = s_ff.rv;
  assign rd_data_o = s_ff.b0;
  assign ad_o = s_ff.ad;
  assign ad_oe_o = s_ff.ad_oe;
  assign data_strobe_n_o = s_ff.strobe_n;
  assign transfer_direction_o = s_ff.dir;
  assign strobe_dir_oe_o = s_ff.sd_oe;
  assign write_read_o = s_ff.dir;
  assign word_address_outputs_o = s_ff.wa;
  assign byte_lane_selects_o = s_ff.be_out;
  assign final_beat_n_o = s_ff.final_n;
  assign bus_oe_o = s_ff.bus_oe;
  assign lock_n_o = 1'b0;
  assign lock_oe_o = s_ff.lock_on;
  assign bus_grant_ack_o = s_ff.grant;
  assign grant_oe_o = s_ff.goe;
  assign all_outputs_float_test_mode_o = s_ff.float_all;
  assign proc_clk_o = s_ff.phase;

  // ==========================================================
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  read_release_a: assert property ($fell(data_strobe_n_o) && !transfer_direction_o |-> !ad_oe_o)
    else $error("line drivers still on at read strobe");
  dir_stable_a: assert property (!data_strobe_n_o && !$past(data_strobe_n_o) |-> $stable(transfer_direction_o))
    else $error("direction moved under strobe");
  wait_extend_a: assert property (s_ff.state == lbc_pkg::BUS_DATA && s_ff.phase && rdy_s2_ff
                                  |=> !data_strobe_n_o[*2])
    else $error("data state ended without ready");
  grant_order_a: assert property ($rose(bus_grant_ack_o) |-> !bus_oe_o && !$past(bus_oe_o, 2))
    else $error("grant before bus floated");
  grant_drop_a: assert property (s_ff.state == lbc_pkg::BUS_HOLD && s_ff.phase && !hold_s2_ff
                                 |=> !bus_grant_ack_o)
    else $error("grant kept after request withdrawn");
  float_mode_a: assert property (s_ff.float_all |-> !bus_oe_o && !ad_oe_o && !lock_oe_o && !strobe_dir_oe_o)
    else $error("output driven in float mode");
  fail_show_a: assert property (s_ff.first && s_ff.mode == lbc_pkg::INI_TEST && !s_ff.float_all
                                |-> !final_beat_n_o && byte_lane_selects_o == lbc_pkg::BE_OFF_N)
    else $error("failure indication missing in self-test");
  lock_addr_a: assert property ($rose(lock_oe_o) |-> s_ff.state == lbc_pkg::BUS_ADDR && !write_read_o)
    else $error("lock raised outside read address state");
  last_beat_a: assert property (!final_beat_n_o && !data_strobe_n_o |-> s_ff.beats == 3'h0)
    else $error("final beat marked early");
  // the edge right after release still compares against reset values
  clk_div_a: assert property ($past(rst_n_i) |-> s_ff.phase != $past(s_ff.phase))
    else $error("processor tick not half rate");
  lane_sel_a: assert property (!data_strobe_n_o |-> byte_lane_selects_o == s_ff.be_n)
    else $error("byte selects wrong in data state");

  rmw_seen_c: cover property (s_ff.read_modify_write_sequence && s_ff.wr && s_ff.state == lbc_pkg::BUS_ADDR);
  hold_seen_c: cover property ($rose(bus_grant_ack_o));
  wait_seen_c: cover property (s_ff.state == lbc_pkg::BUS_DATA && s_ff.phase && rdy_s2_ff);
  burst_seen_c: cover property (!final_beat_n_o && !data_strobe_n_o && word_address_outputs_o == 3'h7);
endmodule
`default_nettype wire

// ===== verilog/lbc_pkg.sv
`default_nettype none
package lbc_pkg;
  // ==========================================================
  // widths and fixed values
  localparam int unsigned AD_W = 16;
  localparam int unsigned SELFTEST_CYCLES = 64;
  localparam logic [1:0] CHK_BURSTS = 2'h2;
  localparam logic [15:0] CHK_STEP = 16'h0010;
  localparam logic [2:0] CHK_LAST_BEAT = 3'h7;
  localparam logic [31:0] CHK_EXPECT = 32'h0000_0000;
  localparam logic STROBE_RST = 1'b1;
  localparam logic DIR_RST = 1'b1;
  localparam logic GRANT_RST = 1'b0;
  localparam logic [1:0] BE_OFF_N = 2'h3;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  // ==========================================================
  // states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_ADDR = 3'h1,
    BUS_DATA = 3'h3,
    BUS_REL = 3'h2,
    BUS_HOLD = 3'h6
  } lbc_bus_type;
  typedef enum logic [1:0] {
    INI_TEST = 2'h0,
    INI_SUM = 2'h1,
    INI_RUN = 2'h3,
    INI_FAIL = 2'h2
  } lbc_init_type;
endpackage
`default_nettype wire

// ===== verification/lbc_mem_model.sv
`default_nettype none
module lbc_mem_model (
  // clock
  input wire logic clk_i,
  // device bus pins
  input wire logic [15:0] ad_o_i,
  input wire logic ad_oe_i,
  input wire logic data_strobe_n_i,
  input wire logic transfer_direction_i,
  input wire logic [2:0] word_address_i,
  input wire logic [2:0] wait_i,
  // answers
  output logic [15:0] ad_i_o,
  output logic ready_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] base_ff;
  logic [2:0] wa_ff;
  logic [3:0] cnt_ff;
  logic [15:0] rdata;
  logic drive;
  // ==========================================================
  // read data: lowest 16 halfwords (32 bytes) are zero for the checksum
  assign rdata = (base_ff[15:5] == 11'h000) ? 16'h0000 : ({base_ff[15:4], word_address_i, 1'b0} ^ 16'h5A00);
  assign drive = !data_strobe_n_i && !transfer_direction_i;
  // released lines show the inverse, never a stale value
  assign ad_i_o = drive ? rdata : ~ad_o_i;
  // ==========================================================
  // ready pulse; retried when the beat was not taken (buffer full)
  initial ready_n_o = 1'b1;
  always @(posedge clk_i)
  begin
    if (ad_oe_i && data_strobe_n_i)
      base_ff <= ad_o_i;
    wa_ff <= word_address_i;
    if (data_strobe_n_i || wa_ff != word_address_i || cnt_ff == {1'b0, wait_i} + 4'hB)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= cnt_ff + 4'h1;
    ready_n_o <= !(!data_strobe_n_i && cnt_ff >= {1'b0, wait_i} + 4'h2 && cnt_ff < {1'b0, wait_i} + 4'h4);
  end
endmodule
`default_nettype wire

// ===== verification/lbc_local_bus_ctl_tb.sv
`default_nettype none
module lbc_local_bus_ctl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_n_i, req_valid_i, req_ready_o, req_write_i, req_rmw_i, req_inta_i, selftest_ok_i, rd_valid_o;
  logic rd_ready_i, ad_oe_o, data_strobe_n_o, transfer_direction_o, strobe_dir_oe_o, write_read_o, final_beat_n_o;
  logic bus_oe_o, ready_n_i, lock_n_i, lock_n_o, lock_oe_o, hold_i, bus_grant_ack_o, grant_oe_o, proc_clk_o;
  logic all_outputs_float_test_mode_o, other_lock, run, stall, dir_first, p;
  logic [2:0] req_last_beat_i, word_address_outputs_o, wait_sel;
  logic [1:0] req_be_n_i, byte_lane_selects_o;
  logic [15:0] req_addr_i, req_wdata_i, rd_data_o, ad_i, ad_o;
  logic [22:0] tq[$];
  logic [15:0] rq[$];
  logic [22:0] t;
  logic [31:0] r;
  int err_total = 0, tests_run = 0, seed = 32'hb1c3, k, i;
  lbc_local_bus_ctl #(.SELFTEST_CYCLES(2)) lbc_local_bus_ctl_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_rmw_i(req_rmw_i),
    .req_inta_i(req_inta_i), .req_last_beat_i(req_last_beat_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_be_n_i(req_be_n_i), .selftest_ok_i(selftest_ok_i), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o),
    .data_strobe_n_o(data_strobe_n_o), .transfer_direction_o(transfer_direction_o),
    .strobe_dir_oe_o(strobe_dir_oe_o), .write_read_o(write_read_o), .word_address_outputs_o(word_address_outputs_o),
    .byte_lane_selects_o(byte_lane_selects_o), .final_beat_n_o(final_beat_n_o), .bus_oe_o(bus_oe_o),
    .ready_n_i(ready_n_i), .lock_n_i(lock_n_i), .lock_n_o(lock_n_o), .lock_oe_o(lock_oe_o), .hold_i(hold_i),
    .bus_grant_ack_o(bus_grant_ack_o), .grant_oe_o(grant_oe_o),
    .all_outputs_float_test_mode_o(all_outputs_float_test_mode_o), .proc_clk_o(proc_clk_o));
  lbc_mem_model lbc_mem_model_i (.clk_i(clk_i), .ad_o_i(ad_o), .ad_oe_i(ad_oe_o), .data_strobe_n_i(data_strobe_n_o),
    .transfer_direction_i(transfer_direction_o), .word_address_i(word_address_outputs_o),
    .wait_i(wait_sel & 3'h3), .ad_i_o(ad_i), .ready_n_o(ready_n_i));
  // open-drain lock with pull-up
  assign lock_n_i = !(lock_oe_o && !lock_n_o) && !other_lock;
  // ==========================================================
  // helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic give_up(input string name);
    err_total++;
    $display("ERROR %s expected event seen timeout", name);
    finish_test();
  endtask
  task automatic do_reset(input logic lk, input logic ok);
    run = 1'b0;
    rst_n_i = 1'b0;
    other_lock = lk;
    selftest_ok_i = ok;
    repeat (12) @(negedge clk_i);
    check("data_strobe_n_o", data_strobe_n_o, 1'b1);
    check("transfer_direction_o", transfer_direction_o, 1'b1);
    check("bus_grant_ack_o", bus_grant_ack_o, 1'b0);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    other_lock = 1'b0;
  endtask
  // kinds: w write, m locked read-modify-write, a interrupt acknowledge
  task automatic req(input logic w, m, a, input logic [2:0] lb, input logic [15:0] ad, wd, input logic [1:0] be);
    logic [2:0] n;
    n = (w | m | a) ? 3'h0 : lb;
    if (!w || m || a)
      for (int b = 0; b <= n; b++)
        rq.push_back({ad[15:4], ad[3:1] + b[2:0], 1'b0} ^ 16'h5A00);
    tq.push_back({m | a, w & !m & !a, n, be, wd});
    if (m)
      tq.push_back({1'b0, 1'b1, 3'h0, be, wd});
    wait_sel = r[23:21];
    req_write_i = w;
    req_rmw_i = m;
    req_inta_i = a;
    req_last_beat_i = lb;
    req_addr_i = ad;
    req_wdata_i = wd;
    req_be_n_i = be;
    req_valid_i = 1'b1;
    for (i = 0; i < 4000 && req_ready_o !== 1'b1; i++)
      @(negedge clk_i);
    if (i == 4000)
      give_up("req_ready_o");
    @(negedge clk_i);
    req_valid_i = 1'b0;
  endtask
  // ==========================================================
  // stimulus clock and read-side stall
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(negedge clk_i)
    rd_ready_i <= !stall && (($random(seed) & 3) != 0);
  // ==========================================================
  // monitors
  always @(negedge clk_i)
  begin
    if (run && !data_strobe_n_o && p)
    begin
      t = tq.pop_front();
      check("lock_oe_o", lock_oe_o, t[22]);
      check("transfer_direction_o", transfer_direction_o, t[21]);
      check("final_beat_n_o", final_beat_n_o, t[20:18] != 3'h0);
      check("byte_lane_selects_o", byte_lane_selects_o, t[17:16]);
      check("ad_oe_o", ad_oe_o, t[21]);
      if (t[21])
        check("ad_o", ad_o, t[15:0]);
      dir_first = transfer_direction_o;
    end
    if (run && !data_strobe_n_o)
      check("write_read_o", {transfer_direction_o, write_read_o}, {2{dir_first}});
    p = data_strobe_n_o;
  end
  always @(posedge clk_i)
    if (run && rd_valid_o === 1'b1 && rd_ready_i)
      check("rd_data_o", rd_data_o, rq.pop_front());
  // ==========================================================
  // main sequence
  initial
  begin
    {req_valid_i, req_write_i, req_rmw_i, req_inta_i, hold_i, stall, p, wait_sel} = 10'h000;
    {req_last_beat_i, req_addr_i, req_wdata_i, req_be_n_i, r} = 69'h0;
    do_reset(1'b0, 1'b1);
    for (i = 0; i < 20 && final_beat_n_o !== 1'b0; i++)
      @(negedge clk_i);
    if (i == 20)
      give_up("final_beat_n_o");
    check("byte_lane_selects_o", byte_lane_selects_o, 2'h3);
    dir_first = proc_clk_o;
    @(negedge clk_i);
    check("proc_clk_o", proc_clk_o, !dir_first);
    for (i = 0; i < 4000 && req_ready_o !== 1'b1; i++)
      @(negedge clk_i);
    if (i == 4000)
      give_up("req_ready_o");
    check("final_beat_n_o", final_beat_n_o, 1'b1);
    run = 1'b1;
    for (k = 0; k < 16; k++)
    begin
      r = $random(seed);
      stall = (k == 4);
      other_lock = (k == 2);
      req(k % 4 == 1, k % 4 == 2, k % 4 == 3, stall ? 3'h7 : r[18:16], {r[15:5] | 11'h001, r[4:0]}, r[31:16],
        r[20:19]);
      repeat (30) @(negedge clk_i);
      if (k == 2)
        check("ad_oe_o", ad_oe_o, 1'b0);
      if (k == 4)
        check("data_strobe_n_o", data_strobe_n_o, 1'b0);
      {stall, other_lock} = 2'h0;
    end
    for (i = 0; i < 4000 && (tq.size() != 0 || rq.size() != 0); i++)
      @(negedge clk_i);
    if (i == 4000)
      give_up("queues");
    repeat (20) @(negedge clk_i);
    hold_i = 1'b1;
    for (i = 0; i < 100 && bus_grant_ack_o !== 1'b1; i++)
      @(negedge clk_i);
    if (i == 100)
      give_up("bus_grant_ack_o");
    check("bus_oe_o", {bus_oe_o, ad_oe_o, bus_grant_ack_o}, 3'h1);
    hold_i = 1'b0;
    for (i = 0; i < 100 && bus_grant_ack_o !== 1'b0; i++)
      @(negedge clk_i);
    if (i == 100)
      give_up("bus_grant_ack_o");
    check("bus_grant_ack_o", bus_grant_ack_o, 1'b0);
    do_reset(1'b0, 1'b0);
    repeat (40) @(negedge clk_i);
    check("final_beat_n_o", {final_beat_n_o, req_ready_o}, 2'h0);
    do_reset(1'b1, 1'b1);
    repeat (4) @(negedge clk_i);
    check("float_mode", {all_outputs_float_test_mode_o, grant_oe_o, bus_oe_o, ad_oe_o}, 4'h8);
    finish_test();
  end
endmodule
`default_nettype wire
